// ===== verilog/lirq_pkg.sv
// package for the local interrupt error, timer and ipi block
// assumes a single bus clock and a word-wide register port from the core
package lirq_pkg;

    // ************************************************************
    // register offsets within the 4k window (byte addresses)
    // ************************************************************
    localparam logic [11:0] OFF_ERR_STATUS = 12'h280;
    localparam logic [11:0] OFF_CMD_LO = 12'h300;
    localparam logic [11:0] OFF_CMD_HI = 12'h310;
    localparam logic [11:0] OFF_LVT_TIMER = 12'h320;
    localparam logic [11:0] OFF_LVT_ERROR = 12'h370;
    localparam logic [11:0] OFF_INIT_COUNT = 12'h380;
    localparam logic [11:0] OFF_CUR_COUNT = 12'h390;
    localparam logic [11:0] OFF_DIV_CONFIG = 12'h3e0;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ERR_SEND_CKSUM = 0;
    localparam int ERR_RECV_CKSUM = 1;
    localparam int ERR_SEND_ACCEPT = 2;
    localparam int ERR_RECV_ACCEPT = 3;
    localparam int ERR_SEND_VEC = 5;
    localparam int ERR_RECV_VEC = 6;
    localparam int ERR_ILL_ADDR = 7;
    localparam int LVT_MASK_BIT = 16;
    localparam int LVT_MODE_BIT = 17;
    localparam int CMD_STATUS_BIT = 12;
    localparam logic [7:0] ERR_IMPL = 8'hef;
    localparam logic [7:0] VEC_LEGAL_MIN = 8'h10;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] LVT_RESET = 32'h0001_0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [3:0] DIV_RESET = 4'h0;
    localparam logic [63:0] CMD_RESET = 64'h0000_0000_0000_0000;

    // register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    // interrupt delivered to the core
    typedef struct packed {
        logic valid;
        logic [7:0] vector;
    } irq_msg_t;

    // error events from the message path
    typedef struct packed {
        logic send_cksum;
        logic recv_cksum;
        logic send_accept;
        logic recv_accept;
        logic send_vec;
        logic recv_vec;
    } err_evt_t;

    typedef enum logic [1:0] {
        DLV_IDLE,
        DLV_TIMER,
        DLV_ERROR
    } dlv_state_t;

endpackage

// ===== verilog/lirq_err_timer_ipi.sv
// error status, timer, local delivery retry and ipi command logic
// assumes core register port, accept/reject answers and bus link are
// synchronous to CLK
`timescale 1ns/1ps
`default_nettype none

module lirq_err_timer_ipi
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // register port from the core
    input wire lirq_pkg::reg_req_t REQ,
    output logic [31:0] RDATA,
    output logic RVALID,
    // error events from the message path
    input wire lirq_pkg::err_evt_t ERR_EVT,
    input wire logic [7:0] RECV_VEC,
    input wire logic RECV_VEC_VALID,
    // local interrupt to the core
    output lirq_pkg::irq_msg_t IRQ,
    input wire logic IRQ_ACCEPT,
    input wire logic IRQ_REJECT,
    // ipi send port
    output logic [63:0] IPI_CMD,
    output logic IPI_SEND,
    input wire logic IPI_DONE
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [31:0] lvt_timer_q;
    logic [31:0] lvt_error_q;
    logic [31:0] init_count_q;
    logic [31:0] cur_count_q;
    logic [3:0] div_q;
    logic [7:0] err_pend_q;
    logic [7:0] err_vis_q;
    logic err_wr_last_q;
    logic [6:0] pre_q;
    logic running_q;
    logic timer_pend_q;
    logic error_pend_q;
    lirq_pkg::dlv_state_t dlv_q;

    logic [11:0] a;
    logic hit;
    logic wr_err;
    logic wr_init;
    logic tick;
    logic timer_fire;
    logic [7:0] new_err;
    logic err_raise;
    logic [6:0] pre_mask;

    assign a = REQ.addr;
    assign wr_err = CE && REQ.wr && a == lirq_pkg::OFF_ERR_STATUS;
    assign wr_init = CE && REQ.wr && a == lirq_pkg::OFF_INIT_COUNT;

    function automatic logic wr_cmd_lo_send();
        return CE && REQ.wr && a == lirq_pkg::OFF_CMD_LO
            && !IPI_CMD[lirq_pkg::CMD_STATUS_BIT];
    endfunction

    always_comb
    begin
        case (a)
            lirq_pkg::OFF_ERR_STATUS, lirq_pkg::OFF_CMD_LO,
            lirq_pkg::OFF_CMD_HI, lirq_pkg::OFF_LVT_TIMER,
            lirq_pkg::OFF_LVT_ERROR, lirq_pkg::OFF_INIT_COUNT,
            lirq_pkg::OFF_CUR_COUNT, lirq_pkg::OFF_DIV_CONFIG:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
    end

    // ************************************************************
    // error detection
    // ************************************************************
    always_comb
    begin
        new_err = 8'h00;
        new_err[lirq_pkg::ERR_SEND_CKSUM] = ERR_EVT.send_cksum;
        new_err[lirq_pkg::ERR_RECV_CKSUM] = ERR_EVT.recv_cksum;
        new_err[lirq_pkg::ERR_SEND_ACCEPT] = ERR_EVT.send_accept;
        new_err[lirq_pkg::ERR_RECV_ACCEPT] = ERR_EVT.recv_accept;
        // send side: ipi launched with an illegal vector
        new_err[lirq_pkg::ERR_SEND_VEC] = ERR_EVT.send_vec
            || (wr_cmd_lo_send() && REQ.wdata[7:0]
                < lirq_pkg::VEC_LEGAL_MIN);
        // receive side: message, or local timer and error entries
        new_err[lirq_pkg::ERR_RECV_VEC] = ERR_EVT.recv_vec
            || (RECV_VEC_VALID && RECV_VEC < lirq_pkg::VEC_LEGAL_MIN)
            || (dlv_q == lirq_pkg::DLV_IDLE && timer_pend_q
                && !lvt_timer_q[lirq_pkg::LVT_MASK_BIT]
                && lvt_timer_q[7:0] < lirq_pkg::VEC_LEGAL_MIN)
            || (dlv_q == lirq_pkg::DLV_IDLE && error_pend_q
                && !lvt_error_q[lirq_pkg::LVT_MASK_BIT]
                && lvt_error_q[7:0] < lirq_pkg::VEC_LEGAL_MIN);
        new_err[lirq_pkg::ERR_ILL_ADDR] = (REQ.wr || REQ.rd) && !hit;
        if (!CE || lvt_error_q[lirq_pkg::LVT_MASK_BIT])
            new_err = 8'h00;
    end

    assign err_raise = |(new_err & ~err_pend_q);

    // ************************************************************
    // error status: pending flags, visible copy, clear sequence
    // ************************************************************
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            err_pend_q <= 8'h00;
            err_vis_q <= 8'h00;
            err_wr_last_q <= 1'b0;
        end
        else if (CE)
        begin
            if (wr_err && err_wr_last_q)
            begin
                // second write with no read in between clears; new events still land
                err_pend_q <= new_err;
                err_vis_q <= 8'h00;
            end
            else
            begin
                err_pend_q <= err_pend_q | new_err;
                if (wr_err)
                    err_vis_q <= (err_pend_q | new_err)
                        & lirq_pkg::ERR_IMPL;
            end
            err_wr_last_q <= wr_err || (err_wr_last_q && !REQ.rd);
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            lvt_timer_q <= lirq_pkg::LVT_RESET;
            lvt_error_q <= lirq_pkg::LVT_RESET;
            init_count_q <= lirq_pkg::ZERO32;
            div_q <= lirq_pkg::DIV_RESET;
        end
        else if (CE && REQ.wr)
        begin
            case (a)
                lirq_pkg::OFF_LVT_TIMER:
                    lvt_timer_q <= REQ.wdata & 32'h0003_00ff;
                lirq_pkg::OFF_LVT_ERROR:
                    lvt_error_q <= REQ.wdata & 32'h0001_00ff;
                lirq_pkg::OFF_INIT_COUNT:
                    init_count_q <= REQ.wdata;
                lirq_pkg::OFF_DIV_CONFIG:
                    div_q <= {REQ.wdata[3], REQ.wdata[1:0], 1'b0};
                default:
                    ;
            endcase
        end
    end

    // ************************************************************
    // timer prescaler: code 111 divides by 1, others by 2^(n+1)
    // ************************************************************
    assign pre_mask = (div_q == 4'he) ? 7'h00
        : 7'(({4'h0, 3'h1} << div_q[3:1]) << 1) - 7'h01;

    assign tick = running_q && ((pre_q & pre_mask) == pre_mask);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            pre_q <= 7'h00;
        end
        else if (CE)
            pre_q <= wr_init ? 7'h00 : pre_q + 7'h01;
    end

    // ************************************************************
    // down-counter
    // ************************************************************
    assign timer_fire = tick && cur_count_q == 32'h0000_0001;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cur_count_q <= lirq_pkg::ZERO32;
            running_q <= 1'b0;
        end
        else if (CE)
        begin
            if (wr_init)
            begin
                cur_count_q <= REQ.wdata;
                running_q <= REQ.wdata != lirq_pkg::ZERO32;
            end
            else if (timer_fire)
            begin
                if (lvt_timer_q[lirq_pkg::LVT_MODE_BIT])
                    cur_count_q <= init_count_q;
                else
                begin
                    cur_count_q <= lirq_pkg::ZERO32;
                    running_q <= 1'b0;
                end
            end
            else if (tick)
                cur_count_q <= cur_count_q - 32'h0000_0001;
        end
    end

    // ************************************************************
    // local delivery with retry on reject
    // ************************************************************
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            timer_pend_q <= 1'b0;
            error_pend_q <= 1'b0;
            dlv_q <= lirq_pkg::DLV_IDLE;
            IRQ <= '0;
        end
        else if (CE)
        begin
            case (dlv_q)
                lirq_pkg::DLV_IDLE:
                begin
                    if (timer_pend_q
                        && !lvt_timer_q[lirq_pkg::LVT_MASK_BIT])
                    begin
                        IRQ.valid <= 1'b1;
                        IRQ.vector <= lvt_timer_q[7:0];
                        dlv_q <= lirq_pkg::DLV_TIMER;
                    end
                    else if (error_pend_q
                        && !lvt_error_q[lirq_pkg::LVT_MASK_BIT])
                    begin
                        IRQ.valid <= 1'b1;
                        IRQ.vector <= lvt_error_q[7:0];
                        dlv_q <= lirq_pkg::DLV_ERROR;
                    end
                end
                lirq_pkg::DLV_TIMER, lirq_pkg::DLV_ERROR:
                begin
                    if (IRQ_ACCEPT || IRQ_REJECT)
                    begin
                        // a reject leaves the source pending: retried
                        IRQ.valid <= 1'b0;
                        dlv_q <= lirq_pkg::DLV_IDLE;
                    end
                end
                default:
                    dlv_q <= lirq_pkg::DLV_IDLE;
            endcase
            // set wins over the accept that clears it
            if (timer_fire && !lvt_timer_q[lirq_pkg::LVT_MASK_BIT])
                timer_pend_q <= 1'b1;
            else if (dlv_q == lirq_pkg::DLV_TIMER && IRQ_ACCEPT)
                timer_pend_q <= 1'b0;
            if (err_raise && !lvt_error_q[lirq_pkg::LVT_MASK_BIT])
                error_pend_q <= 1'b1;
            else if (dlv_q == lirq_pkg::DLV_ERROR && IRQ_ACCEPT)
                error_pend_q <= 1'b0;
        end
    end

    // ************************************************************
    // ipi command register
    // ************************************************************
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            IPI_CMD <= lirq_pkg::CMD_RESET;
            IPI_SEND <= 1'b0;
        end
        else if (CE)
        begin
            IPI_SEND <= 1'b0;
            if (REQ.wr && a == lirq_pkg::OFF_CMD_HI)
                IPI_CMD[63:32] <= REQ.wdata;
            if (wr_cmd_lo_send())
            begin
                IPI_CMD[31:0] <= REQ.wdata
                    | (32'h1 << lirq_pkg::CMD_STATUS_BIT);
                IPI_SEND <= 1'b1;
            end
            else if (IPI_DONE)
                IPI_CMD[lirq_pkg::CMD_STATUS_BIT] <= 1'b0;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RDATA <= lirq_pkg::ZERO32;
            RVALID <= 1'b0;
        end
        else if (CE)
        begin
            RVALID <= REQ.rd;
            case (a)
                lirq_pkg::OFF_ERR_STATUS:
                    RDATA <= {24'h000000, err_vis_q};
                lirq_pkg::OFF_CMD_LO:
                    RDATA <= IPI_CMD[31:0];
                lirq_pkg::OFF_CMD_HI:
                    RDATA <= IPI_CMD[63:32];
                lirq_pkg::OFF_LVT_TIMER:
                    RDATA <= lvt_timer_q | (32'(timer_pend_q) << 12);
                lirq_pkg::OFF_LVT_ERROR:
                    RDATA <= lvt_error_q | (32'(error_pend_q) << 12);
                lirq_pkg::OFF_INIT_COUNT:
                    RDATA <= init_count_q;
                lirq_pkg::OFF_CUR_COUNT:
                    RDATA <= cur_count_q;
                lirq_pkg::OFF_DIV_CONFIG:
                    RDATA <= {28'h0000000, div_q[3], 1'b0, div_q[2:1]};
                default:
                    RDATA <= lirq_pkg::ZERO32;
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== testbench/lirq_err_timer_ipi_sva.sv
// checker for the error, timer and ipi block
// sees only the top ports; bound from the testbench top
`timescale 1ns/1ps
`default_nettype none
module lirq_err_timer_ipi_sva
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // register port
    input wire lirq_pkg::reg_req_t REQ,
    input wire logic [31:0] RDATA,
    input wire logic RVALID,
    // error events
    input wire lirq_pkg::err_evt_t ERR_EVT,
    input wire logic [7:0] RECV_VEC,
    input wire logic RECV_VEC_VALID,
    // core and ipi
    input wire lirq_pkg::irq_msg_t IRQ,
    input wire logic IRQ_ACCEPT,
    input wire logic IRQ_REJECT,
    input wire logic [63:0] IPI_CMD,
    input wire logic IPI_SEND,
    input wire logic IPI_DONE
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic rd_take;
    logic esr_wr;
    logic lo_wr;
    assign rd_take = CE && REQ.rd;
    assign esr_wr = CE && REQ.wr && REQ.addr == lirq_pkg::OFF_ERR_STATUS;
    assign lo_wr = CE && REQ.wr && REQ.addr == lirq_pkg::OFF_CMD_LO;

    rd_answer_a: assert property (rd_take |=> RVALID)
        else $error("read not answered");
    rd_cause_a: assert property (RVALID |-> $past(rd_take))
        else $error("read answer without read");
    unmapped_zero_a: assert property (rd_take && REQ.addr == 12'h3f0
        |=> RDATA == 32'h0)
        else $error("unmapped read not zero");
    status_clear_a: assert property (esr_wr ##1 esr_wr ##1 (rd_take
        && REQ.addr == lirq_pkg::OFF_ERR_STATUS) |=> RDATA == 32'h0)
        else $error("status not cleared");
    ipi_send_a: assert property (lo_wr && !IPI_CMD[12] |=> IPI_SEND)
        else $error("low write sent nothing");
    ipi_refuse_a: assert property (IPI_CMD[12] && !IPI_DONE
        |=> !IPI_SEND)
        else $error("send while busy");
    ipi_busy_a: assert property (IPI_SEND |-> IPI_CMD[12])
        else $error("busy not shown on send");
    busy_hold_a: assert property (IPI_CMD[12] && !IPI_DONE
        |=> IPI_CMD[12])
        else $error("busy dropped early");
    irq_hold_a: assert property (IRQ.valid && !IRQ_ACCEPT && !IRQ_REJECT
        |=> IRQ.valid && $stable(IRQ.vector))
        else $error("interrupt offer not held");
    irq_retry_a: assert property (IRQ.valid && IRQ_REJECT
        |-> ##[1:4] IRQ.valid)
        else $error("rejected interrupt not retried");
endmodule
`default_nettype wire

// ===== testbench/lirq_core_model.sv
// model of the core and the ipi link beside the block
// assumes answers are sampled by the block at CLK
`timescale 1ns/1ps
`default_nettype none
module lirq_core_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // core side
    input wire lirq_pkg::irq_msg_t irq,
    input wire logic reject_mode,
    output logic irq_accept,
    output logic irq_reject,
    output logic [7:0] acc_cnt,
    output logic [7:0] rej_cnt,
    output logic [7:0] last_vec,
    // link side
    input wire logic ipi_send,
    output logic ipi_done,
    output logic [7:0] send_cnt
);
    // ****************************************
    // acceptance, slow by two cycles
    // ****************************************
    logic [1:0] wait_q;
    logic rejected_q;
    logic [3:0] dly_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {wait_q, rejected_q, irq_accept, irq_reject} <= '0;
            {acc_cnt, rej_cnt, last_vec} <= '0;
        end
        else
        begin
            irq_accept <= 1'b0;
            irq_reject <= 1'b0;
            if (irq.valid && !irq_accept && !irq_reject)
            begin
                wait_q <= wait_q + 2'h1;
                if (wait_q == 2'h2)
                begin
                    wait_q <= 2'h0;
                    rejected_q <= reject_mode && !rejected_q;
                    // every other offer refused in reject mode
                    if (reject_mode && !rejected_q)
                    begin
                        irq_reject <= 1'b1;
                        rej_cnt <= rej_cnt + 8'h1;
                    end
                    else
                    begin
                        irq_accept <= 1'b1;
                        acc_cnt <= acc_cnt + 8'h1;
                        last_vec <= irq.vector;
                    end
                end
            end
        end
    end
    // link finishes a send eight cycles on
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            {dly_q, ipi_done, send_cnt} <= '0;
        else
        begin
            ipi_done <= dly_q == 4'h1;
            if (ipi_send)
                send_cnt <= send_cnt + 8'h1;
            dly_q <= ipi_send ? 4'h8 : dly_q - {3'h0, dly_q != 4'h0};
        end
    end
endmodule
`default_nettype wire

// ===== testbench/lirq_err_timer_ipi_tb_top.sv
// top testbench for the error, timer and ipi block
// assumes the checker and core model files are compiled first
`timescale 1ns/1ps
`default_nettype none
module lirq_err_timer_ipi_tb_top;
    localparam logic [11:0] ES = lirq_pkg::OFF_ERR_STATUS;
    localparam logic [11:0] CUR = lirq_pkg::OFF_CUR_COUNT;
    localparam logic [11:0] INI = lirq_pkg::OFF_INIT_COUNT;
    localparam logic [11:0] LO = lirq_pkg::OFF_CMD_LO;
    logic CLK, RST, CE, RECV_VEC_VALID, IRQ_ACCEPT, IRQ_REJECT, RVALID;
    logic IPI_SEND, IPI_DONE, rej_mode;
    logic [7:0] RECV_VEC, acc_cnt, rej_cnt, last_vec, send_cnt, n;
    logic [31:0] RDATA, e;
    logic [63:0] IPI_CMD;
    lirq_pkg::reg_req_t REQ;
    lirq_pkg::err_evt_t ERR_EVT;
    lirq_pkg::irq_msg_t IRQ;
    int miscompares, compares;

    lirq_err_timer_ipi u_lirq_err_timer_ipi (.CLK(CLK), .RST(RST),
        .CE(CE), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID),
        .ERR_EVT(ERR_EVT), .RECV_VEC(RECV_VEC),
        .RECV_VEC_VALID(RECV_VEC_VALID), .IRQ(IRQ),
        .IRQ_ACCEPT(IRQ_ACCEPT), .IRQ_REJECT(IRQ_REJECT),
        .IPI_CMD(IPI_CMD), .IPI_SEND(IPI_SEND), .IPI_DONE(IPI_DONE));
    lirq_core_model u_lirq_core_model (.clk(CLK), .rst(RST), .irq(IRQ),
        .reject_mode(rej_mode), .irq_accept(IRQ_ACCEPT),
        .irq_reject(IRQ_REJECT), .acc_cnt(acc_cnt), .rej_cnt(rej_cnt),
        .last_vec(last_vec), .ipi_send(IPI_SEND), .ipi_done(IPI_DONE),
        .send_cnt(send_cnt));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(logic w, logic r, logic [11:0] a, logic [31:0] d);
        @(posedge CLK);
        REQ <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        put(1'b1, 1'b0, a, d);
        put(1'b0, 1'b0, a, 32'h0);
    endtask
    task automatic rdc(logic [11:0] a, logic [31:0] exp);
        put(1'b0, 1'b1, a, 32'h0);
        put(1'b0, 1'b0, a, 32'h0);
        #1;
        chk(RVALID, 1'b1);
        chk(RDATA, exp);
    endtask
    task automatic error_status(logic [31:0] exp);
        wr(ES, 32'h0);
        rdc(ES, exp);
    endtask
    task automatic clr;
        put(1'b1, 1'b0, ES, 32'h0);
        put(1'b1, 1'b0, ES, 32'h0);
        rdc(ES, 32'h0);
    endtask
    task automatic ev(lirq_pkg::err_evt_t v);
        @(posedge CLK);
        ERR_EVT <= v;
        @(posedge CLK);
        ERR_EVT <= '0;
        repeat (20) @(posedge CLK);
    endtask
    task automatic vec(logic [7:0] v);
        @(posedge CLK);
        RECV_VEC <= v;
        RECV_VEC_VALID <= 1'b1;
        @(posedge CLK);
        RECV_VEC_VALID <= 1'b0;
        repeat (20) @(posedge CLK);
    endtask
    task automatic wait_irq(logic [7:0] c);
        for (int i = 0; i < 1200 && acc_cnt == c; i++)
            @(posedge CLK);
        repeat (4) @(posedge CLK);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rdc(lirq_pkg::OFF_LVT_TIMER, lirq_pkg::LVT_RESET);
        rdc(lirq_pkg::OFF_LVT_ERROR, lirq_pkg::LVT_RESET);
        rdc(INI, 32'h0);
        rdc(CUR, 32'h0);
        rdc(ES, 32'h0);
    endtask
    task automatic t_errors;
        wr(lirq_pkg::OFF_LVT_ERROR, 32'h40);
        e = 32'h0;
        n = acc_cnt;
        for (int i = 0; i < 6; i++)
        begin
            ev(6'h20 >> i);
            if (i == 0)
                rdc(ES, 32'h0);
            e[i < 4 ? i : i + 1] = 1'b1;
            error_status(e);
            chk(acc_cnt, n + 8'(i + 1));
            chk(last_vec, 8'h40);
        end
        clr();
    endtask
    task automatic t_vectors;
        vec(8'h10);
        error_status(32'h0);
        vec(8'h0f);
        error_status(32'h40);
        rdc(12'h3f0, 32'h0);
        error_status(32'hc0);
        clr();
    endtask
    task automatic t_mask;
        ev(6'h10);
        error_status(32'h2);
        wr(lirq_pkg::OFF_LVT_ERROR, 32'h0001_0040);
        n = acc_cnt;
        ev(6'h08);
        error_status(32'h2);
        chk(acc_cnt, n);
        wr(lirq_pkg::OFF_LVT_ERROR, 32'h40);
        clr();
    endtask
    task automatic t_oneshot;
        rej_mode <= 1'b1;
        wr(lirq_pkg::OFF_DIV_CONFIG, 32'ha);
        wr(lirq_pkg::OFF_LVT_TIMER, 32'h50);
        n = rej_cnt;
        wr(INI, 32'h3);
        rdc(INI, 32'h3);
        rdc(CUR, 32'h3);
        repeat (60) @(posedge CLK);
        rdc(CUR, 32'h3);
        e = {24'h0, acc_cnt};
        wait_irq(acc_cnt);
        rdc(CUR, 32'h0);
        chk(rej_cnt, n + 8'h1);
        chk(last_vec, 8'h50);
        wr(CUR, 32'h7);
        repeat (400) @(posedge CLK);
        rdc(CUR, 32'h0);
        chk(acc_cnt, e[7:0] + 8'h1);
        rej_mode <= 1'b0;
    endtask
    task automatic t_restart;
        n = acc_cnt;
        wr(INI, 32'h100);
        repeat (300) @(posedge CLK);
        wr(INI, 32'h5);
        rdc(CUR, 32'h5);
        wait_irq(acc_cnt);
        chk(acc_cnt, n + 8'h1);
    endtask
    task automatic t_periodic;
        wr(lirq_pkg::OFF_DIV_CONFIG, 32'hb);
        wr(lirq_pkg::OFF_LVT_TIMER, 32'h0002_0050);
        n = acc_cnt;
        wr(INI, 32'd40);
        repeat (220) @(posedge CLK);
        chk(acc_cnt, n + 8'h5);
        put(1'b0, 1'b1, CUR, 32'h0);
        put(1'b0, 1'b0, CUR, 32'h0);
        #1;
        chk(RDATA != 32'h0 && RDATA <= 32'd40, 1'b1);
        wr(lirq_pkg::OFF_LVT_TIMER, 32'h0001_0050);
    endtask
    task automatic t_ipi;
        n = send_cnt;
        wr(lirq_pkg::OFF_CMD_HI, 32'h0a00_0000);
        wr(LO, 32'h35);
        #1;
        chk(IPI_CMD, 64'h0a00_0000_0000_1035);
        wr(LO, 32'h36);
        repeat (12) @(posedge CLK);
        chk(send_cnt, n + 8'h1);
        rdc(lirq_pkg::OFF_CMD_HI, 32'h0a00_0000);
        wr(LO, 32'h1005);
        repeat (12) @(posedge CLK);
        rdc(LO, 32'h5);
        chk(IPI_CMD, 64'h0a00_0000_0000_0005);
        chk(send_cnt, n + 8'h2);
        error_status(32'h20);
    endtask

    task automatic report_and_stop;
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    initial
    begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial
    begin
        {RST, CE, rej_mode} = 3'b110;
        {REQ, ERR_EVT, RECV_VEC, RECV_VEC_VALID} = '0;
        {miscompares, compares} = '0;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        t_reset();
        t_errors();
        t_vectors();
        t_mask();
        t_oneshot();
        t_restart();
        t_periodic();
        t_ipi();
        report_and_stop();
    end
endmodule

bind lirq_err_timer_ipi lirq_err_timer_ipi_sva u_sva (.CLK(CLK),
    .RST(RST), .CE(CE), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID),
    .ERR_EVT(ERR_EVT), .RECV_VEC(RECV_VEC),
    .RECV_VEC_VALID(RECV_VEC_VALID), .IRQ(IRQ), .IRQ_ACCEPT(IRQ_ACCEPT),
    .IRQ_REJECT(IRQ_REJECT), .IPI_CMD(IPI_CMD), .IPI_SEND(IPI_SEND),
    .IPI_DONE(IPI_DONE));
`default_nettype wire
